//--- verilog/table_access_consts.vh
// Constants for the table read/write execution block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef TABLE_ACCESS_CONSTS_VH
`define TABLE_ACCESS_CONSTS_VH

`define OPC_PREFIX      12'h000    // Bits 15:4 of both opcodes, all zero
`define OPC_SEL_READ    2'h2       // Bits 3:2 for table read
`define OPC_SEL_WRITE   2'h3       // Bits 3:2 for table write
`define MODE_NONE       2'h0       // Pointer unchanged
`define MODE_POSTINC    2'h1       // Pointer + 1 after access
`define MODE_POSTDEC    2'h2       // Pointer - 1 after access
`define MODE_PREINC     2'h3       // Pointer + 1 before access
`define PTR_WIDTH       21         // Byte pointer width
`define PTR_RESET       21'h00_0000
`define LATCH_RESET     8'h00
`define HOLD_SEL_WIDTH  3          // Low pointer bits that pick a holding byte
`define HOLD_RESET      8'hFF      // Erased value of a holding byte
`define PTR_ONE         21'h00_0001

`endif

//--- verilog/hold_byte_mem.v
// Holding registers for table writes: a small byte memory, one write
// port and one registered read port. Assumes a single clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "table_access_consts.vh"

module hold_byte_mem #(
  parameter AW = `HOLD_SEL_WIDTH              // Address width
) (
  input  wire          clk,                   // Core clock
  input  wire          rstn,                  // Async reset, active low
  input  wire          wrEn,                  // Write strobe
  input  wire [AW-1:0] wrAddr,                // Write address
  input  wire [7:0]    wrData,                // Write data
  input  wire [AW-1:0] rdAddr,                // Read address
  output reg  [7:0]    rdData                 // Registered read data
);

  reg [7:0] mem [0:(1<<AW)-1];
  genvar g;

  // Each byte resets to the erased value so a partial row programs safely
  generate
    for (g = 0; g < (1<<AW); g = g + 1) begin : gByte
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          mem[g] <= `HOLD_RESET;
        end else if (wrEn && wrAddr == g) begin
          mem[g] <= wrData;
        end
      end
    end
  endgenerate

  // Read data registered
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= `HOLD_RESET;
    end else begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

`default_nettype wire

//--- verilog/table_access.v
// Table read/write execution unit: runs the two table instructions using
// a byte pointer and a byte latch. Assumes the decoder presents an opcode
// with a one-cycle strobe and that program memory answers a read request
// with a one-cycle valid pulse some cycles later.
// Only one table instruction runs at a time; an opcode offered while busy
// is dropped, so the decoder must stall until busy falls.
//
// Notes on behaviour
// - Read opcode is twelve zeros then 10; low two bits pick pointer mode.
// - Read loads addressed byte into latch; post modes adjust after, preinc before.
// - Pointer is 21-bit byte address; each step moves exactly one byte.
// - Pointer bit zero picks low byte (0) or high byte (1) of word.
// - Write stores latch into selected holding byte, same modes, effective at completion.
// - Small package variant: table write unavailable in normal operation.
// - Large variant: write effective only when targeting external memory.
`timescale 1ns/1ns
`default_nettype none
`include "table_access_consts.vh"

module table_access #(
  parameter PW = `PTR_WIDTH,                  // Pointer width
  parameter HW = `HOLD_SEL_WIDTH              // Holding select width
) (
  input  wire          clk,                   // Core clock
  input  wire          rstn,                  // Async reset, active low
  input  wire          opValid,               // Opcode strobe from decoder
  input  wire [15:0]   opWord,                // Instruction word
  input  wire          smallPkg,              // Small package variant
  input  wire          extMemTarget,          // Pointer targets external memory
  input  wire          ptrLoad,               // Software pointer load strobe
  input  wire [PW-1:0] ptrLoadVal,            // Pointer load value
  input  wire          latchLoad,             // Software latch load strobe
  input  wire [7:0]    latchLoadVal,          // Latch load value
  input  wire          memRdValid,            // Program memory read data valid
  input  wire [7:0]    memRdData,             // Program memory read byte
  input  wire [HW-1:0] holdRdAddr,            // Holding byte read address
  output wire          busy,                  // Instruction in progress
  output reg           opDone,                // One-cycle completion pulse
  output reg           opRejected,            // Write refused pulse
  output reg           memRdReq,              // Program memory read request
  output reg  [PW-1:0] memAddr,               // Program memory byte address
  output reg           extWrReq,              // External write request
  output reg  [PW-1:0] extWrAddr,             // External write address
  output reg  [7:0]    extWrData,             // External write byte
  output reg  [PW-1:0] tablePtr_ff,           // table_byte_pointer
  output reg  [7:0]    tableLatch_ff,         // table_byte_latch
  output wire [7:0]    holdRdData             // Holding byte read data
);

  // One-hot states: idle, waiting for read data, writing the holding byte
  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_WRIT = 3'b100;

  // Registered state and the combinational next values
  reg [2:0]    state_ff;
  reg [2:0]    nxt_state;
  reg [1:0]    mode_ff;
  reg [1:0]    nxt_mode;
  reg [PW-1:0] nxt_ptr;
  reg          holdWr;

  // Pointer step; wraps modulo the 2-Mbyte space
  function [PW-1:0] stepPtr;
    input [PW-1:0] p;
    input [1:0]    m;
    begin
      case (m)
        `MODE_POSTINC, `MODE_PREINC: stepPtr = p + `PTR_ONE;
        `MODE_POSTDEC:               stepPtr = p - `PTR_ONE;
        default:                     stepPtr = p;
      endcase
    end
  endfunction

  // Opcode class decode, shared by both instructions
  function isTableOp;
    input [15:0] w;
    input [1:0]  sel;
    begin
      isTableOp = (w[15:4] == `OPC_PREFIX) && (w[3:2] == sel);
    end
  endfunction

  wire isRead  = opValid && isTableOp(opWord, `OPC_SEL_READ);
  wire isWrite = opValid && isTableOp(opWord, `OPC_SEL_WRITE);
  wire wrAllow = !smallPkg && extMemTarget;
  // Accepted read and its completion, shared by several processes below
  wire takeRead = state_ff[0] && isRead;
  wire readDone = state_ff[1] && memRdValid;

  // Busy is combinational so the decoder can stall in the very cycle
  assign busy = !state_ff[0];

  // Sequencing: the pre-increment is applied as the access starts so the
  // access uses the new address; post modes adjust at completion.
  always @* begin
    nxt_state = state_ff;
    nxt_mode  = mode_ff;
    nxt_ptr   = tablePtr_ff;
    holdWr    = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (isRead || (isWrite && wrAllow)) begin
          nxt_mode  = opWord[1:0];
          nxt_state = isRead ? ST_READ : ST_WRIT;
          if (opWord[1:0] == `MODE_PREINC) begin
            nxt_ptr = stepPtr(tablePtr_ff, `MODE_PREINC);
          end
        end else if (ptrLoad) begin
          nxt_ptr = ptrLoadVal;
        end
      end
      ST_READ: begin
        if (memRdValid) begin
          nxt_state = ST_IDLE;
          if (mode_ff != `MODE_PREINC) begin
            nxt_ptr = stepPtr(tablePtr_ff, mode_ff);
          end
        end
      end
      ST_WRIT: begin
        holdWr    = 1'b1;
        nxt_state = ST_IDLE;
        if (mode_ff != `MODE_PREINC) begin
          nxt_ptr = stepPtr(tablePtr_ff, mode_ff);
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State, mode and pointer. The pointer moves only through nxt_ptr, so a
  // software load and a table step can never land in the same cycle.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= ST_IDLE;
      mode_ff     <= `MODE_NONE;
      tablePtr_ff <= `PTR_RESET;
    end else begin
      state_ff    <= nxt_state;
      mode_ff     <= nxt_mode;
      tablePtr_ff <= nxt_ptr;
    end
  end

  // Read request, issued once per table read and addressed by the pointer
  // after any pre-increment. The address is held while the read is open
  // because the memory side may need several cycles to answer.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      memRdReq <= 1'b0;
      memAddr  <= `PTR_RESET;
    end else begin
      memRdReq <= takeRead;
      if (takeRead) begin
        memAddr <= nxt_ptr;
      end
    end
  end

  // Completion and refusal pulses, one cycle each. A refused write leaves
  // the pointer and the holding bytes untouched: it never leaves idle.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opDone     <= 1'b0;
      opRejected <= 1'b0;
    end else begin
      opDone     <= readDone || state_ff[2];
      opRejected <= state_ff[0] && isWrite && !wrAllow;
    end
  end

  // External write port. Address and data are captured with the holding
  // write, so the memory interface sees the byte the holding array got.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extWrReq  <= 1'b0;
      extWrAddr <= `PTR_RESET;
      extWrData <= `LATCH_RESET;
    end else begin
      extWrReq <= holdWr;
      if (holdWr) begin
        extWrAddr <= tablePtr_ff;
        extWrData <= tableLatch_ff;
      end
    end
  end

  // Table latch. A completing read wins over a software load; loads are
  // taken only while idle, so in practice the two never meet.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tableLatch_ff <= `LATCH_RESET;
    end else if (readDone) begin
      tableLatch_ff <= memRdData;
    end else if (state_ff[0] && latchLoad) begin
      tableLatch_ff <= latchLoadVal;
    end
  end

  // Holding bytes picked by the low pointer bits; bit zero picks LSB/MSB
  hold_byte_mem #(
    .AW (HW)
  ) uHold (
    .clk    (clk),
    .rstn   (rstn),
    .wrEn   (holdWr),
    .wrAddr (tablePtr_ff[HW-1:0]),
    .wrData (tableLatch_ff),
    .rdAddr (holdRdAddr),
    .rdData (holdRdData)
  );

endmodule

`default_nettype wire

//--- testbench/table_access_assertions.sv
// Port checker for the table access unit.
// Assumes one core clock and the async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module table_access_assertions #(
  parameter PW = 21,                          // Pointer width
  parameter HW = 3                            // Holding select width
) (
  input wire logic          clk,              // Core clock
  input wire logic          rstn,             // Async reset, active low
  input wire logic          opValid,          // Opcode strobe
  input wire logic [15:0]   opWord,           // Instruction word
  input wire logic          smallPkg,         // Small package variant
  input wire logic          extMemTarget,     // External memory target
  input wire logic          busy,             // Instruction in progress
  input wire logic          memRdValid,       // Read data valid
  input wire logic [7:0]    memRdData,        // Read byte
  input wire logic          memRdReq,         // Read request
  input wire logic [PW-1:0] memAddr,          // Read address
  input wire logic          opDone,           // Completion pulse
  input wire logic          opRejected,       // Refusal pulse
  input wire logic          extWrReq,         // External write request
  input wire logic [PW-1:0] extWrAddr,        // External write address
  input wire logic [7:0]    extWrData,        // External write byte
  input wire logic [PW-1:0] tablePtr_ff,      // Byte pointer
  input wire logic [7:0]    tableLatch_ff     // Byte latch
);
  // Taken opcodes; busy gates repeats
  wire logic       rdT = opValid && !busy && opWord[15:2] == 14'h0002;
  wire logic       wrT = opValid && !busy && opWord[15:2] == 14'h0003;
  wire logic       ok  = !smallPkg && extMemTarget;
  wire logic [1:0] md  = opWord[1:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_read_request: assert property (rdT |=> memRdReq)
    else $error("no read request");
  a_read_addr: assert property (rdT && md != 2'h3 |=> memAddr == $past(tablePtr_ff))
    else $error("read address");
  a_preinc_addr: assert property (rdT && md == 2'h3 |=>
    memAddr == $past(tablePtr_ff) + 1'b1) else $error("preinc address");
  a_latch_capture: assert property (busy && memRdValid |=> opDone
    && tableLatch_ff == $past(memRdData)) else $error("latch capture");
  a_write_issue: assert property (wrT && ok && md != 2'h3 |=> ##1 extWrReq
    && extWrAddr == $past(tablePtr_ff, 2) && extWrData == $past(tableLatch_ff, 2))
    else $error("write issue");
  a_write_preinc: assert property (wrT && ok && md == 2'h3 |=> ##1 extWrReq
    && extWrAddr == $past(tablePtr_ff, 2) + 1'b1) else $error("preinc write");
  a_write_postdec: assert property (wrT && ok && md == 2'h2 |=> ##1
    tablePtr_ff == $past(tablePtr_ff, 2) - 1'b1) else $error("postdec");
  a_small_refuse: assert property (wrT && smallPkg |=> opRejected && !extWrReq
    && $stable(tablePtr_ff)) else $error("small refuse");
  a_ext_refuse: assert property (wrT && !smallPkg && !extMemTarget |=> opRejected
    ##1 !extWrReq) else $error("ext refuse");
endmodule
bind table_access table_access_assertions #(
  .PW (PW),
  .HW (HW)
) chkU (
  .clk           (clk),
  .rstn          (rstn),
  .opValid       (opValid),
  .opWord        (opWord),
  .smallPkg      (smallPkg),
  .extMemTarget  (extMemTarget),
  .busy          (busy),
  .memRdValid    (memRdValid),
  .memRdData     (memRdData),
  .memRdReq      (memRdReq),
  .memAddr       (memAddr),
  .opDone        (opDone),
  .opRejected    (opRejected),
  .extWrReq      (extWrReq),
  .extWrAddr     (extWrAddr),
  .extWrData     (extWrData),
  .tablePtr_ff   (tablePtr_ff),
  .tableLatch_ff (tableLatch_ff)
);
`default_nettype wire

//--- testbench/prog_mem_model.sv
// Program memory stand-in answering each read request with one byte.
// Assumes memAddr holds while a read is outstanding.
`timescale 1ns/1ns
`default_nettype none
module prog_mem_model (
  input wire logic        clk,                       // Core clock
  input wire logic        rstn,                      // Async reset, active low
  input wire logic        slow,                      // Long answer delay when high
  input wire logic        memRdReq,                  // Read request
  input wire logic [20:0] memAddr,                   // Byte address
  output var logic        memRdValid,                // Data strobe
  output var logic [7:0]  memRdData                  // Byte, toggles when not valid
);
  logic [2:0] cnt_ff;
  // Content depends on the byte address, so an off-by-one read shows
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {cnt_ff, memRdValid, memRdData} <= 12'h000;
    end else begin
      memRdValid <= cnt_ff == 3'h1;
      memRdData <= cnt_ff == 3'h1 ? memAddr[7:0] ^ 8'h5A : ~memRdData;
      cnt_ff <= memRdReq ? (slow ? 3'h4 : 3'h1) : cnt_ff - {2'h0, cnt_ff != 3'h0};
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb_program_memory_table_access.sv
// Bench for the table access unit with a program memory model.
// Assumes the checker binds itself to the unit.
`timescale 1ns/1ns
`default_nettype none
module tb_program_memory_table_access;
  logic clk, rstn, opValid, smallPkg, extMemTarget, ptrLoad, latchLoad, slow;
  logic [15:0] opWord;
  logic [20:0] ptrLoadVal;
  logic [7:0]  latchLoadVal;
  logic [2:0]  holdRdAddr;
  wire logic   busy, opDone, opRejected, memRdReq, memRdValid, extWrReq;
  wire logic [20:0] memAddr, extWrAddr, tablePtr_ff;
  wire logic [7:0]  memRdData, extWrData, tableLatch_ff, holdRdData;
  int badCount = 0, checkCount = 0;
  table_access dut_u (
    .clk           (clk),
    .rstn          (rstn),
    .opValid       (opValid),
    .opWord        (opWord),
    .smallPkg      (smallPkg),
    .extMemTarget  (extMemTarget),
    .ptrLoad       (ptrLoad),
    .ptrLoadVal    (ptrLoadVal),
    .latchLoad     (latchLoad),
    .latchLoadVal  (latchLoadVal),
    .memRdValid    (memRdValid),
    .memRdData     (memRdData),
    .holdRdAddr    (holdRdAddr),
    .busy          (busy),
    .opDone        (opDone),
    .opRejected    (opRejected),
    .memRdReq      (memRdReq),
    .memAddr       (memAddr),
    .extWrReq      (extWrReq),
    .extWrAddr     (extWrAddr),
    .extWrData     (extWrData),
    .tablePtr_ff   (tablePtr_ff),
    .tableLatch_ff (tableLatch_ff),
    .holdRdData    (holdRdData)
  );
  prog_mem_model memU (
    .clk        (clk),
    .rstn       (rstn),
    .slow       (slow),
    .memRdReq   (memRdReq),
    .memAddr    (memAddr),
    .memRdValid (memRdValid),
    .memRdData  (memRdData)
  );
  // Core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Pointer after one instruction; 21-bit arithmetic so both ends wrap
  function automatic logic [20:0] nextPtr(input logic [20:0] p, input logic [1:0] m);
    nextPtr = (m == 2'h0) ? p : (m == 2'h2) ? p - 21'h00_0001 : p + 21'h00_0001;
  endfunction
  // Pointer and latch load together while idle
  task setup(input logic [20:0] p, input logic [7:0] d);
    @(negedge clk) {ptrLoad, ptrLoadVal, latchLoad, latchLoadVal} = {1'b1, p, 1'b1, d};
    @(negedge clk) {ptrLoad, latchLoad} = 2'b00;
  endtask
  // One opcode, then a bounded wait for completion or refusal
  task runOp(input logic [15:0] w, input logic rej);
    int n;
    @(negedge clk) {opValid, opWord} = {1'b1, w};
    @(negedge clk) opValid = 1'b0;
    check(busy, !rej);
    for (n = 0; n < 20 && opDone !== 1'b1 && opRejected !== 1'b1; n++) @(negedge clk);
    check(n < 20, 1);
    check(opRejected, rej);
  endtask
  task hold(input logic [2:0] a, input logic [7:0] e);
    @(negedge clk) holdRdAddr = a;
    @(negedge clk) check(holdRdData, e);
  endtask
  task rdOne(input logic [20:0] p, input logic [1:0] m);
    logic [20:0] a;
    a = (m == 2'h3) ? p + 21'h00_0001 : p;
    setup(p, 8'h00);
    runOp({14'h0002, m}, 1'b0);
    check(memAddr, a);
    check(tableLatch_ff, a[7:0] ^ 8'h5A);
    check(tablePtr_ff, nextPtr(p, m));
  endtask
  task wrOne(input logic [20:0] p, input logic [1:0] m, input logic [7:0] d);
    logic [20:0] a;
    a = (m == 2'h3) ? p + 21'h00_0001 : p;
    setup(p, d);
    runOp({14'h0003, m}, 1'b0);
    check(tablePtr_ff, nextPtr(p, m));
    check(extWrAddr, a);
    check(extWrData, d);
    hold(a[2:0], d);
  endtask
  // All modes, both paces, and wrap at both ends of the space
  task testRead;
    for (int m = 0; m < 4; m++) begin
      slow = m[0];
      rdOne(21'h00_A356, m[1:0]);
    end
    rdOne(21'h1F_FFFF, 2'h1);
    rdOne(21'h00_0000, 2'h2);
    $display("read test done");
  endtask
  task testWrite;
    {smallPkg, extMemTarget} = 2'b01;
    hold(3'h7, 8'hFF);
    for (int m = 0; m < 4; m++) wrOne(21'h01_389A, m[1:0], {6'h0C, m[1:0]});
    $display("write test done");
  endtask
  // Refused writes must leave pointer and holding bytes alone
  task testRefuse;
    setup(21'h00_0100, 8'hAA);
    smallPkg = 1'b1;
    runOp(16'h000D, 1'b1);
    check(tablePtr_ff, 21'h00_0100);
    {smallPkg, extMemTarget} = 2'b00;
    runOp(16'h000F, 1'b1);
    check(tablePtr_ff, 21'h00_0100);
    hold(3'h0, 8'hFF);
    $display("refuse test done");
  endtask
  task results;
    $display("checks %0d, mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {rstn, opValid, smallPkg, extMemTarget, ptrLoad, latchLoad, slow} = 7'h00;
    {opWord, ptrLoadVal, latchLoadVal, holdRdAddr} = 48'h0000;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    testRead;
    testWrite;
    testRefuse;
    results;
  end
  // Watchdog far beyond the hundred or so cycles needed
  initial begin
    #20000;
    badCount++;
    results;
  end
endmodule
`default_nettype wire
